// file: src/cpu_mode_pkg.sv
// package: constants and types for the cpu mode control core
package cpu_mode_pkg;

    // machine-cycle phases, eight clock pulses per cycle
    localparam logic [2:0] PH_P1   = 3'h1;
    localparam logic [2:0] PH_LO   = 3'h2;
    localparam logic [2:0] PH_WR0  = 3'h4;
    localparam logic [2:0] PH_P2   = 3'h6;
    localparam logic [2:0] PH_LAST = 3'h7;

    typedef enum logic [2:0] {
        ST_INIT  = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC  = 3'b010,
        ST_EXEC2 = 3'b011,
        ST_DMA   = 3'b100,
        ST_INT   = 3'b101,
        ST_IDLE  = 3'b110
    } state_t;

    localparam logic [1:0] SC_FETCH = 2'h0;
    localparam logic [1:0] SC_EXEC  = 2'h1;
    localparam logic [1:0] SC_DMA   = 2'h2;
    localparam logic [1:0] SC_INT   = 2'h3;

    // opcode groups (high nibble) and sub-codes (low nibble)
    localparam logic [3:0] OP_LDN  = 4'h0;
    localparam logic [3:0] OP_INC  = 4'h1;
    localparam logic [3:0] OP_BR   = 4'h3;
    localparam logic [3:0] OP_GRP7 = 4'h7;
    localparam logic [3:0] OP_GRPF = 4'hf;
    localparam logic [3:0] N_DIS   = 4'h1;
    localparam logic [3:0] N_REQ   = 4'ha;
    localparam logic [3:0] N_SEQ   = 4'hb;
    localparam logic [3:0] N_ADD   = 4'h4;
    localparam logic [3:0] N_SHR   = 4'h6;

    localparam logic [3:0]  INT_X   = 4'h2;
    localparam logic [3:0]  INT_P   = 4'h1;
    localparam logic [3:0]  R_PC0   = 4'h0;
    localparam logic        INT_EN_RST = 1'b1;
    localparam logic [15:0] R0_RST  = 16'h0000;

    // register map, byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h04;
    localparam logic [7:0] REG_PC     = 8'h08;
    localparam logic [7:0] REG_CTRL   = 8'h0c;
    localparam int         CTRL_HALT  = 0;
    localparam logic [1:0] RESP_OK    = 2'b00;
    localparam logic [1:0] RESP_ERR   = 2'b10;

    typedef struct packed {
        logic rst;
        logic run;
        logic load;
        logic pause;
    } mode_t;

endpackage : cpu_mode_pkg

// file: src/cpu_mode_control_core.sv
// cpu mode control core: mode decode, cycle sequencer, registers, axi-lite
// Behaviour
// R1: each machine cycle is eight clocks; instructions take two or three cycles
// R2: sixteen 16-bit scratch-pad registers chosen by N, P or X selectors
// R3: chosen register copied to address latch, sent high byte then low byte
// R4: ALU combines accumulator with bus byte; carry flag from add and shift
// R5: clear and wait both high means run mode
// R6: clear low, wait high: reset, zero I N X P Q bus, enable set
// R7: leaving reset runs one init cycle clearing X, P and R0
// R8: in reset both timing pulses quiet and state stays init
// R9: clear and wait low: load mode, DMA bytes stored from address zero
// R10: wait low with clear high halts at next edge, outputs held
// R11: wait high again resumes at the next clock edge
// R12: pause freezes internal operation only, clock keeps running
// R13: while paused no DMA or interrupt is acknowledged
// R14: run begins fetching from address zero with R0 as counter
// R15: pending DMA at run start gives a DMA cycle first
// R16: interrupts ignored during init and until first instruction or DMA
// R17: instruction 71 then byte 00 clears interrupt enable
// R18: outside logic holds DMA off until counter leaves R0
// R19: outside logic gives no interrupt request in load mode
// R20: four active-low flag inputs tested by short branches
// R21: switch-driven flag inputs are debounced outside
// R22: clear and wait synchronised before mode decode
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_control_core
    import cpu_mode_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clear_n,
    input  wire logic        wait_n,
    input  wire logic        dma_in_req_n,
    input  wire logic        int_req_n,
    input  wire logic        ext_flag_input_1_n,
    input  wire logic        ext_flag_input_2_n,
    input  wire logic        ext_flag_input_3_n,
    input  wire logic        ext_flag_input_4_n,
    input  wire logic [7:0]  data_in,
    input  wire logic [7:0]  dma_data_in,
    output logic      [7:0]  mem_addr,
    output logic      [7:0]  data_out,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             timing_pulse_first,
    output logic             timing_pulse_second,
    output logic      [1:0]  state_code,
    output logic             q_out,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp
);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // does the execute cycle of this opcode read memory
    function automatic logic mem_op(input logic [3:0] i, input logic [3:0] n);
        mem_op = (i == OP_LDN && n != 4'h0) || (i == OP_BR) ||
                 (i == OP_GRP7 && n == N_DIS) || (i == OP_GRPF && n == N_ADD);
    endfunction : mem_op

    // scratch-pad index used for the address of a cycle
    function automatic logic [3:0] addr_sel(input state_t s, input logic [3:0] i,
                                            input logic [3:0] n, input logic [3:0] x,
                                            input logic [3:0] p);
        if (s == ST_DMA)
            addr_sel = R_PC0;
        else if (s == ST_EXEC && i == OP_LDN)
            addr_sel = n;
        else if (s == ST_EXEC && i == OP_GRPF)
            addr_sel = x;
        else
            addr_sel = p;
    endfunction : addr_sel

    // clear/wait synchronisers
    logic clr_m_q, clr_s_q, wt_m_q, wt_s_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_m_q <= 1'b0;
            clr_s_q <= 1'b0;
            wt_m_q  <= 1'b1;
            wt_s_q  <= 1'b1;
        end else begin
            clr_m_q <= clear_n; // R22
            clr_s_q <= clr_m_q;
            wt_m_q  <= wait_n;
            wt_s_q  <= wt_m_q;
        end
    end

    logic  halt_q;
    mode_t md;
    always_comb begin
        md.rst   = !clr_s_q && wt_s_q; // R6
        md.load  = !clr_s_q && !wt_s_q; // R9
        md.pause = clr_s_q && (!wt_s_q || halt_q); // R10
        md.run   = clr_s_q && wt_s_q && !halt_q; // R5
    end

    logic       dma_req, int_req, cyc_end;
    logic [3:0] ef_true;
    assign dma_req = !dma_in_req_n;
    assign int_req = !int_req_n;
    assign ef_true = ~{ext_flag_input_4_n, ext_flag_input_3_n,
                       ext_flag_input_2_n, ext_flag_input_1_n}; // R20

    // core state
    state_t      st_q, st_d;
    logic [2:0]  ph_q, ph_d, ph_nx;
    logic [3:0]  i_q, i_d, n_q, n_d, x_q, x_d, p_q, p_d, sel;
    logic [7:0]  d_q, d_d, opnd_q, opnd_d;
    logic        df_q, df_d, int_en_q, int_en_d, q_q, q_d, armed_q, armed_d;
    logic [15:0] a_q, a_d;
    logic [15:0] rf_q [16]; // R2
    logic        rf_we;
    logic [3:0]  rf_wi;
    logic [15:0] rf_wv;
    logic [7:0]  mem_addr_d, data_out_d;
    logic        mem_rd_d, mem_wr_d, tp1_d, tp2_d;
    logic [1:0]  sc_d;
    logic        rd_cyc;
    logic [8:0]  sum;
    assign cyc_end = (ph_q == PH_LAST) && !md.pause && !md.rst;

    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        i_d = i_q;
        n_d = n_q;
        x_d = x_q;
        p_d = p_q;
        d_d = d_q;
        df_d = df_q;
        int_en_d = int_en_q;
        q_d = q_q;
        armed_d = armed_q;
        opnd_d = opnd_q;
        a_d = a_q;
        mem_addr_d = mem_addr;
        data_out_d = data_out;
        mem_rd_d = mem_rd;
        mem_wr_d = mem_wr;
        tp1_d = timing_pulse_first;
        tp2_d = timing_pulse_second;
        sc_d = state_code;
        rf_we = 1'b0;
        rf_wi = 4'h0;
        rf_wv = 16'h0000;
        sel = 4'h0;
        ph_nx = ph_q + 3'h1;
        sum = {1'b0, d_q} + {1'b0, opnd_q};
        rd_cyc = (st_q == ST_FETCH) || (st_q == ST_EXEC && mem_op(i_q, n_q));
        if (md.rst) begin
            st_d = ST_INIT; // R8
            ph_d = 3'h0;
            i_d = 4'h0; // R6
            n_d = 4'h0;
            x_d = 4'h0;
            p_d = 4'h0;
            q_d = 1'b0;
            int_en_d = INT_EN_RST;
            armed_d = 1'b0; // R16
            data_out_d = 8'h00;
            mem_rd_d = 1'b0;
            mem_wr_d = 1'b0;
            tp1_d = 1'b0; // R8
            tp2_d = 1'b0;
        end else if (!md.pause) begin // R10 R11 R12
            ph_d = ph_nx; // R1
            tp1_d = (ph_nx == PH_P1);
            tp2_d = (ph_nx == PH_P2);
            mem_rd_d = rd_cyc && (ph_nx >= PH_LO);
            mem_wr_d = (st_q == ST_DMA) && (ph_nx >= PH_WR0) && (ph_nx <= PH_P2);
            if (st_q == ST_DMA)
                data_out_d = dma_data_in;
            // operand of the disable stays put through its third cycle
            if (ph_q == PH_P2 && st_q != ST_EXEC2) // R17
                opnd_d = (st_q == ST_DMA) ? dma_data_in : data_in;
            if (ph_q == PH_LAST) begin
                st_d = ST_FETCH;
                case (st_q)
                    ST_INIT: begin
                        x_d = 4'h0; // R7
                        p_d = 4'h0;
                        rf_we = 1'b1;
                        rf_wi = R_PC0;
                        rf_wv = R0_RST;
                        if (md.load)
                            st_d = dma_req ? ST_DMA : ST_IDLE; // R9
                        else
                            st_d = dma_req ? ST_DMA : ST_FETCH; // R14 R15
                    end
                    ST_IDLE: begin
                        if (dma_req)
                            st_d = ST_DMA; // R9
                        else if (md.load)
                            st_d = ST_IDLE;
                    end
                    ST_FETCH: begin
                        i_d = opnd_q[7:4];
                        n_d = opnd_q[3:0];
                        rf_we = 1'b1;
                        rf_wi = p_q;
                        rf_wv = rf_q[p_q] + 16'h0001;
                        st_d = ST_EXEC;
                    end
                    ST_EXEC: begin
                        armed_d = 1'b1; // R16
                        if (i_q == OP_LDN && n_q != 4'h0) begin
                            d_d = opnd_q;
                        end else if (i_q == OP_INC) begin
                            rf_we = 1'b1;
                            rf_wi = n_q;
                            rf_wv = rf_q[n_q] + 16'h0001;
                        end else if (i_q == OP_BR) begin
                            rf_we = 1'b1;
                            rf_wi = p_q;
                            if (n_q[3:2] == 2'b01 && ef_true[n_q[1:0]]) // R20
                                rf_wv = {rf_q[p_q][15:8], opnd_q};
                            else
                                rf_wv = rf_q[p_q] + 16'h0001;
                        end else if (i_q == OP_GRP7) begin
                            if (n_q == N_DIS) begin
                                rf_we = 1'b1;
                                rf_wi = p_q;
                                rf_wv = rf_q[p_q] + 16'h0001;
                                st_d = ST_EXEC2; // R1
                            end
                            if (n_q == N_SEQ)
                                q_d = 1'b1;
                            if (n_q == N_REQ)
                                q_d = 1'b0;
                        end else if (i_q == OP_GRPF && n_q == N_ADD) begin
                            d_d = sum[7:0]; // R4
                            df_d = sum[8];
                        end else if (i_q == OP_GRPF && n_q == N_SHR) begin
                            d_d = {1'b0, d_q[7:1]}; // R4
                            df_d = d_q[0];
                        end
                    end
                    ST_EXEC2: begin
                        x_d = opnd_q[7:4]; // R17
                        p_d = opnd_q[3:0];
                        int_en_d = 1'b0;
                    end
                    ST_DMA: begin
                        armed_d = 1'b1; // R16
                        rf_we = 1'b1;
                        rf_wi = R_PC0;
                        rf_wv = rf_q[R_PC0] + 16'h0001; // R9
                    end
                    ST_INT: begin
                        x_d = INT_X;
                        p_d = INT_P;
                        int_en_d = 1'b0;
                    end
                    default: st_d = ST_INIT;
                endcase
                if (st_q inside {ST_EXEC, ST_EXEC2, ST_DMA, ST_INT} &&
                    st_d != ST_EXEC2) begin
                    if (dma_req)
                        st_d = ST_DMA; // R13
                    else if (int_req && int_en_d && armed_d && md.run)
                        st_d = ST_INT; // R16
                    else if (md.load)
                        st_d = ST_IDLE;
                end
                sel = addr_sel(st_d, i_d, n_d, x_d, p_d);
                a_d = (rf_we && rf_wi == sel) ? rf_wv : rf_q[sel]; // R3
                case (st_d)
                    ST_DMA: sc_d = SC_DMA;
                    ST_INT: sc_d = SC_INT;
                    ST_FETCH: sc_d = SC_FETCH;
                    default: sc_d = SC_EXEC;
                endcase
            end
            mem_addr_d = (ph_nx < PH_LO) ? a_d[15:8] : a_d[7:0]; // R3
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_INIT;
            ph_q <= 3'h0;
            i_q <= 4'h0;
            n_q <= 4'h0;
            x_q <= 4'h0;
            p_q <= 4'h0;
            d_q <= 8'h00;
            df_q <= 1'b0;
            int_en_q <= INT_EN_RST;
            q_q <= 1'b0;
            armed_q <= 1'b0;
            opnd_q <= 8'h00;
            a_q <= 16'h0000;
            mem_addr <= 8'h00;
            data_out <= 8'h00;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            timing_pulse_first <= 1'b0;
            timing_pulse_second <= 1'b0;
            state_code <= SC_FETCH;
            q_out <= 1'b0;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            i_q <= i_d;
            n_q <= n_d;
            x_q <= x_d;
            p_q <= p_d;
            d_q <= d_d;
            df_q <= df_d;
            int_en_q <= int_en_d;
            q_q <= q_d;
            armed_q <= armed_d;
            opnd_q <= opnd_d;
            a_q <= a_d;
            mem_addr <= mem_addr_d;
            data_out <= data_out_d;
            mem_rd <= mem_rd_d;
            mem_wr <= mem_wr_d;
            timing_pulse_first <= tp1_d;
            timing_pulse_second <= tp2_d;
            state_code <= sc_d;
            q_out <= q_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (rf_we)
            rf_q[rf_wi] <= rf_wv; // R2
    end

    phase_wrap_a: assert property (cyc_end |=> ph_q == 3'h0) // R1
        else $error("phase did not wrap after eight clocks");
    reset_clear_a: assert property (md.rst |=> st_q == ST_INIT && int_en_q && // R6
        i_q == 4'h0 && x_q == 4'h0 && data_out == 8'h00 && !q_out)
        else $error("reset mode state wrong");
    tp_quiet_a: assert property (md.rst |=> !timing_pulse_first && !timing_pulse_second) // R8
        else $error("timing pulse in reset");
    init_clear_a: assert property (st_q == ST_INIT && cyc_end |=> // R7
        x_q == 4'h0 && p_q == 4'h0 && rf_q[0] == 16'h0000)
        else $error("init cycle did not clear");
    run_start_a: assert property (st_q == ST_INIT && cyc_end && md.run |=> // R14
        st_q == ($past(dma_in_req_n) ? ST_FETCH : ST_DMA))
        else $error("wrong first cycle after reset");
    dma_step_a: assert property (st_q == ST_DMA && cyc_end |=> // R9
        rf_q[0] == $past(rf_q[0]) + 16'h0001)
        else $error("dma counter did not step");
    pause_hold_a: assert property (md.pause |=> $stable(ph_q) && $stable(st_q) && // R10
        $stable(mem_addr) && $stable(data_out) && $stable(mem_wr))
        else $error("outputs moved while paused");
    no_ack_a: assert property (md.pause |=> $stable(state_code) && $stable(armed_q)) // R13
        else $error("request taken while paused");
    int_gate_a: assert property ($rose(st_q == ST_INT) |-> armed_q && $past(int_en_q)) // R16
        else $error("interrupt taken while gated");
    dis_clear_a: assert property (st_q == ST_EXEC2 && cyc_end |=> // R17
        !int_en_q && p_q == $past(opnd_q[3:0]))
        else $error("disable did not clear enable");
    addr_hi_a: assert property (ph_q == PH_P1 && st_q != ST_IDLE && // R3
        st_q != ST_INIT |-> mem_addr == a_q[15:8] ##5 (mem_addr == a_q[7:0] || ph_q < PH_LO))
        else $error("address halves wrong");
    alu_add_a: assert property (st_q == ST_EXEC && cyc_end && i_q == OP_GRPF && // R4
        n_q == N_ADD |=> {df_q, d_q} == {1'b0, $past(d_q)} + {1'b0, $past(opnd_q)})
        else $error("add result wrong");

    // register bus slave
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d, halt_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rdata_d;
    logic [3:0]  ws_q, ws_d;
    logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;

    always_comb begin
        aw_have_d = aw_have_q | (awvalid && awready);
        w_have_d = w_have_q | (wvalid && wready);
        awa_d = (awvalid && awready) ? awaddr : awa_q;
        wd_d = (wvalid && wready) ? wdata : wd_q;
        ws_d = (wvalid && wready) ? wstrb : ws_q;
        halt_d = halt_q;
        bvalid_d = bvalid && !bready;
        bresp_d = bresp;
        rvalid_d = rvalid && !rready;
        rdata_d = rdata;
        rresp_d = rresp;
        if (aw_have_d && w_have_d && !bvalid) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_ERR;
            if (awa_d == REG_CTRL) begin
                bresp_d = RESP_OK;
                if (ws_d[0])
                    halt_d = wd_d[CTRL_HALT];
            end
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OK;
            if (araddr == REG_STATUS)
                rdata_d = {21'h0, armed_q, int_en_q, df_q, q_q, md, st_q};
            else if (araddr == REG_ACC)
                rdata_d = {20'h0, ef_true, d_q};
            else if (araddr == REG_PC)
                rdata_d = {16'h0, rf_q[p_q]};
            else if (araddr == REG_CTRL)
                rdata_d = {31'h0, halt_q};
            else begin
                rdata_d = 32'h0000_0000;
                rresp_d = RESP_ERR;
            end
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            halt_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OK;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            halt_q <= halt_d;
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rdata <= rdata_d;
            rresp <= rresp_d;
        end
    end

endmodule : cpu_mode_control_core
`default_nettype wire

// file: test/mem_model.sv
// memory model answering the core's address and data lines
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic       aclk,
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] data_out,
    input  wire logic       mem_rd,
    input  wire logic       mem_wr,
    input  wire logic       timing_pulse_second,
    output logic      [7:0] data_in
);
    logic [7:0] mem [256];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        data_in = 8'h00;
    end
    // released bus toggles each clock between the last byte and its inverse
    always @(posedge aclk) begin
        if (mem_wr && timing_pulse_second) mem[mem_addr] <= data_out;
        data_in <= mem_rd ? mem[mem_addr] : ~data_in;
    end
endmodule : mem_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the cpu mode control core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpu_mode_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, clear_n = 1'b0, wait_n = 1'b1;
    logic        dma_in_req_n = 1'b1, int_req_n = 1'b1;
    logic [3:0]  flg_n = 4'hf, wstrb = 4'hf;
    logic [7:0]  dma_data_in = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [7:0]  data_in, mem_addr, data_out;
    logic        mem_rd, mem_wr, timing_pulse_first, timing_pulse_second, q_out;
    logic [1:0]  state_code, bresp, rresp, rsp;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [22:0] snap;
    int          errors = 0, n_checks = 0, n;
    always #2 aclk = ~aclk;
    cpu_mode_control_core u_dut (
        .aclk, .aresetn, .clear_n, .wait_n, .dma_in_req_n, .int_req_n,
        .ext_flag_input_1_n(flg_n[0]), .ext_flag_input_2_n(flg_n[1]),
        .ext_flag_input_3_n(flg_n[2]), .ext_flag_input_4_n(flg_n[3]),
        .data_in, .dma_data_in, .mem_addr, .data_out, .mem_rd, .mem_wr,
        .timing_pulse_first, .timing_pulse_second, .state_code, .q_out,
        .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp
    );
    mem_model u_mem (.aclk, .mem_addr, .data_out, .mem_rd, .mem_wr,
        .timing_pulse_second, .data_in);
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task final_report;
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc
    task axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axw
    task axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axr
    task dma_put(input logic [7:0] b);
        dma_data_in <= b;
        dma_in_req_n <= 1'b0;
        do @(posedge aclk); while (!(state_code === SC_DMA && timing_pulse_first === 1'b1));
        dma_in_req_n <= 1'b1;
        do @(posedge aclk); while (timing_pulse_second !== 1'b1);
    endtask : dma_put
    initial begin
        cyc(20000);
        errors++;
        final_report();
    end
    initial begin
        cyc(4);
        aresetn <= 1'b1;
        cyc(6);
        n = 0;
        repeat (12) begin
            @(posedge aclk);
            n += timing_pulse_first | timing_pulse_second;
        end
        chk("pulses_in_reset", n, 0);
        chk("bus_in_reset", {q_out, data_out}, 9'h000);
        axr(REG_STATUS);
        chk("status_reset", {rd[9], rd[6:0]}, {INT_EN_RST, 4'b1000, ST_INIT});
        axr(8'h40);
        chk("unmapped_resp", {rsp, rd[29:0]}, {RESP_ERR, 30'h0});
        axw(REG_CTRL, 32'h1);
        axr(REG_CTRL);
        chk("ctrl_rw", {rsp, rd[0]}, {RESP_OK, 1'b1});
        axw(REG_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            flg_n <= ~(4'h1 << i);
            cyc(3);
            axr(REG_ACC);
            chk("flags", rd[11:8], 4'h1 << i);
        end
        flg_n <= 4'hf;
        wait_n <= 1'b0; // no interrupt requests while loading
        dma_put(8'h71);
        dma_put(8'h00);
        dma_put(8'h7b);
        cyc(1);
        chk("loaded", {u_mem.mem[0], u_mem.mem[1], u_mem.mem[2]}, 24'h71007b);
        axr(REG_STATUS);
        chk("status_load", rd[6:3], 4'b0010);
        wait_n <= 1'b1;
        cyc(10);
        clear_n <= 1'b1;
        do @(posedge aclk); while (!(timing_pulse_second === 1'b1 && state_code === SC_FETCH));
        chk("first_fetch", mem_addr, 8'h00);
        do @(posedge aclk); while (timing_pulse_first !== 1'b1);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (timing_pulse_first !== 1'b1);
        chk("cycle_len", n, 8);
        cyc(60);
        axr(REG_STATUS);
        chk("int_en", {rd[9], rd[7], q_out}, 3'b011);
        wait_n <= 1'b0;
        cyc(5);
        dma_in_req_n <= 1'b0;
        int_req_n <= 1'b0;
        cyc(1);
        snap = {mem_addr, data_out, state_code, mem_rd, mem_wr, timing_pulse_first,
            timing_pulse_second, q_out};
        repeat (16) begin
            @(posedge aclk);
            chk("paused", {mem_addr, data_out, state_code, mem_rd, mem_wr,
                timing_pulse_first, timing_pulse_second, q_out}, snap);
        end
        dma_in_req_n <= 1'b1; // held off while counter is still R0
        int_req_n <= 1'b1;
        cyc(2);
        wait_n <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (timing_pulse_first !== 1'b1 && n < 20);
        chk("resume", n < 20, 1);
        clear_n <= 1'b0;
        cyc(10);
        dma_data_in <= 8'h71;
        dma_in_req_n <= 1'b0;
        clear_n <= 1'b1;
        repeat (2) do @(posedge aclk); while (timing_pulse_first !== 1'b1);
        chk("dma_first", state_code, SC_DMA);
        dma_in_req_n <= 1'b1;
        int_req_n <= 1'b0;
        do @(posedge aclk); while (timing_pulse_first !== 1'b1);
        chk("int_taken", state_code, SC_INT);
        final_report();
    end
endmodule : testbench
`default_nettype wire
